// >>> san_an_if.sv
// carrier between the negotiation core and its register helpers
`timescale 1ns/100ps
interface san_an_if;
  logic        ctl_wr;
  logic        adv_wr;
  logic        sts_wr;
  logic [15:0] wdata;
  logic [15:0] ctl_pend;
  logic [15:0] ctl_act;
  logic        apply;
  logic        done;
  logic        sgmii;
  logic [15:0] rx_word;
  logic [15:0] sts;
  logic [15:0] pba;

  modport shadow (
    input  ctl_wr, adv_wr, wdata,
    output ctl_pend, ctl_act, apply
  );
  modport capture (
    input  done, sgmii, rx_word, sts_wr, wdata,
    output sts, pba
  );
  modport core (
    output ctl_wr, adv_wr, sts_wr, wdata, done, sgmii, rx_word,
    input  ctl_pend, ctl_act, apply, sts, pba
  );
endinterface

// >>> san_autoneg_properties.sv
// concurrent checks on the auto-negotiation block's ports
`timescale 1ns/100ps
module san_autoneg_properties #(
  parameter int unsigned LINK_TMR_CYC = san_pkg::LINK_TMR_CYC
) (
  // clock, reset and register port
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] rd_data_o,
  // link and results
  input  wire logic        rx_sync_i,
  input  wire logic        rx_cfg_valid_i,
  input  wire logic [15:0] rx_cfg_word_i,
  input  wire logic [15:0] tx_cfg_word_o,
  input  wire logic        tx_cfg_en_o,
  input  wire logic        an_done_o,
  input  wire logic        link_up_o,
  input  wire logic [1:0]  speed_o,
  input  wire logic        duplex_o,
  input  wire logic        irq_o
);
  wire logic adv_wr = wr_i && addr_i == san_pkg::ADV_OFS;
  wire logic clr_wr = wr_i && addr_i == san_pkg::STS_OFS &&
                      !wr_data_i[san_pkg::STS_DONE_BIT];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence ctl_wr_s;
    wr_i && addr_i == san_pkg::CTL_OFS;
  endsequence
  sequence ctl_rd_s;
    rd_i && !wr_i && addr_i == san_pkg::CTL_OFS;
  endsequence

  a_irq_needs_flag: assert property (irq_o |-> an_done_o)
    else $error("interrupt high without completion flag");
  a_flag_sticky: assert property (an_done_o && !clr_wr |=> an_done_o)
    else $error("completion flag dropped without clear write");
  a_flag_cause: assert property ($rose(an_done_o) |-> !tx_cfg_en_o)
    else $error("completion flag set while still negotiating");
  a_fields_with_flag: assert property (
    $changed({link_up_o, speed_o, duplex_o}) |-> an_done_o)
    else $error("result fields changed without completion");
  a_irq_fell_flag: assert property ($fell(an_done_o) |-> !irq_o)
    else $error("interrupt stayed after flag cleared");
  a_irq_apply_on: assert property (
    $rose(irq_o) && $past(an_done_o) |-> $past(adv_wr) || $past(adv_wr, 2))
    else $error("interrupt enabled without advertisement write");
  a_irq_apply_off: assert property (
    $fell(irq_o) && an_done_o |-> $past(adv_wr) || $past(adv_wr, 2))
    else $error("interrupt disabled without advertisement write");
  a_ctl_readback: assert property (
    ctl_wr_s ##2 ctl_rd_s
    |=> rd_data_o == ($past(wr_data_i, 3) & san_pkg::CTL_WMASK))
    else $error("control read back differs from masked write");
  a_sts_readback: assert property (
    rd_i && !wr_i && addr_i == san_pkg::STS_OFS |=> rd_data_o ==
    {11'h000, $past(link_up_o), $past(speed_o), $past(duplex_o),
     $past(an_done_o)})
    else $error("status read differs from result outputs");
endmodule

bind san_autoneg_top san_autoneg_properties #(
  .LINK_TMR_CYC(LINK_TMR_CYC)
) i_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .rx_sync_i(rx_sync_i), .rx_cfg_valid_i(rx_cfg_valid_i),
  .rx_cfg_word_i(rx_cfg_word_i), .tx_cfg_word_o(tx_cfg_word_o),
  .tx_cfg_en_o(tx_cfg_en_o), .an_done_o(an_done_o), .link_up_o(link_up_o),
  .speed_o(speed_o), .duplex_o(duplex_o), .irq_o(irq_o)
);

// >>> san_autoneg_top.sv
// serial gigabit auto-negotiation core with its register port
// Function
// - control writes take effect on advertisement write
// - bit 3 picks mac-side or phy-side role
// - bits 2:1 pick serdes or sgmii negotiation
// - bit 0 lets completion drive interrupt
// - status bit 4 shows partner link state
// - status bits 3:2 show partner speed
// - status bit 1 shows partner duplex
// - completion flag sticky, cleared by writing zero
// - completion flag ignores interrupt enable
// - serdes results go to partner ability word
`timescale 1ns/100ps
module san_autoneg_top #(
  parameter int unsigned LINK_TMR_CYC = san_pkg::LINK_TMR_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // register port
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rd_data_o,
  // receive side of the pcs
  input  wire logic        rx_sync_i,
  input  wire logic        rx_cfg_valid_i,
  input  wire logic [15:0] rx_cfg_word_i,
  // transmit side of the pcs
  output logic      [15:0] tx_cfg_word_o,
  output logic             tx_cfg_en_o,
  // results
  output logic             an_done_o,
  output logic             link_up_o,
  output logic      [1:0]  speed_o,
  output logic             duplex_o,
  output logic             irq_o
);
  typedef enum logic [2:0] {
    ST_BREAK,
    ST_ABILITY,
    ST_ACK,
    ST_LINKW,
    ST_UP
  } san_state_t;

  san_an_if an ();

  san_state_t       state;
  san_state_t       next_state;
  logic [15:0]      adv_word;
  logic [4:0]       brk_cnt;
  logic [san_pkg::TMR_W-1:0] tmr;
  logic [15:0]      last_word;
  logic [1:0]       match_cnt;
  logic [15:0]      abil_word;
  logic             done;
  logic [7:0]       try_cnt;
  logic [7:0]       up_cnt;
  logic [15:0]      next_tx;
  logic             restart;
  logic             matched;
  logic             ack_ok;
  logic             tmr_hit;
  logic             brk_hit;
  logic [1:0]       mode;
  logic             role_phy;
  logic             adv_link;
  logic             is_sgmii;
  logic [15:0]      ack_mask;
  logic [15:0]      ability_tx;
  logic [15:0]      next_rd_data;

  // one read-table entry per mapped register
  localparam int RD_N = 5;
  localparam logic [20:0] RD_OFS [RD_N] = '{
    san_pkg::CTL_OFS, san_pkg::STS_OFS, san_pkg::ADV_OFS,
    san_pkg::PBA_OFS, san_pkg::DBG_OFS
  };
  logic [15:0]      rd_val [RD_N];
  logic [15:0]      rd_sel [RD_N];
  logic [RD_N-1:0]  rd_hit;

  localparam logic [4:0] BRK_LAST = 5'(san_pkg::BREAK_CYC - 1);
  localparam logic [san_pkg::TMR_W-1:0] TMR_LAST =
    san_pkg::TMR_W'(LINK_TMR_CYC - 1);

  // register helpers
  san_ctl_shadow u_shadow (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .an      (an.shadow)
  );

  san_result_capture u_capture (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .an      (an.capture)
  );

  // write decode
  assign an.ctl_wr = wr_i && (addr_i == san_pkg::CTL_OFS);
  assign an.adv_wr = wr_i && (addr_i == san_pkg::ADV_OFS);
  assign an.sts_wr = wr_i && (addr_i == san_pkg::STS_OFS);
  assign an.wdata  = wr_data_i;
  assign an.done   = done;
  assign an.sgmii  = is_sgmii;
  assign an.rx_word = last_word;

  // only the applied control copy steers negotiation
  assign mode     = an.ctl_act[san_pkg::CTL_MODE_LSB +: 2];
  assign role_phy = an.ctl_act[san_pkg::CTL_ROLE_BIT];
  assign adv_link = an.ctl_act[san_pkg::CTL_LINK_BIT];
  // reserved codes fall back to serdes framing
  assign is_sgmii = (mode == san_pkg::MODE_SGMII);
  assign ack_mask = 16'h0001 << san_pkg::CW_ACK_BIT;

  // advertisement word; its write also releases the pending control
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      adv_word <= san_pkg::ADV_RST;
    end else if (an.adv_wr) begin
      adv_word <= wr_data_i;
    end
  end

  // consistency tracking of received configuration words
  // only valid words count, so a partner idling between words still matches
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_word <= 16'h0000;
      match_cnt <= 2'h0;
    end else if (state != next_state) begin
      match_cnt <= 2'h0;
    end else if (rx_cfg_valid_i) begin
      last_word <= rx_cfg_word_i;
      if (rx_cfg_word_i != last_word) begin
        match_cnt <= 2'h1;
      end else if (match_cnt != san_pkg::MATCH_CNT) begin
        match_cnt <= match_cnt + 2'h1;
      end
    end
  end

  assign matched = (match_cnt == san_pkg::MATCH_CNT);
  // acknowledge must repeat the ability seen earlier
  assign ack_ok = matched && last_word[san_pkg::CW_ACK_BIT] &&
                  ((last_word & ~ack_mask) == (abil_word & ~ack_mask));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      abil_word <= 16'h0000;
    end else if (state == ST_ABILITY && matched) begin
      abil_word <= last_word;
    end
  end

  // a new applied control or loss of sync starts over
  // apply is registered, so break starts with the new control in place
  assign restart = an.apply || !rx_sync_i;
  assign brk_hit = (brk_cnt == BRK_LAST);
  assign tmr_hit = (tmr == TMR_LAST);

  always_comb begin
    next_state = state;
    case (state)
      ST_BREAK: begin
        if (brk_hit) begin
          next_state = ST_ABILITY;
        end
      end
      ST_ABILITY: begin
        if (matched && last_word != 16'h0000) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        if (ack_ok) begin
          next_state = ST_LINKW;
        end else if (matched && last_word == 16'h0000) begin
          next_state = ST_BREAK;
        end
      end
      ST_LINKW: begin
        if (tmr_hit) begin
          next_state = ST_UP;
        end
      end
      ST_UP: begin
        // partner sending a break again means it restarted
        if (rx_cfg_valid_i && rx_cfg_word_i == 16'h0000) begin
          next_state = ST_BREAK;
        end
      end
      default: begin
        next_state = ST_BREAK;
      end
    endcase
    if (restart) begin
      next_state = ST_BREAK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_BREAK;
    end else begin
      state <= next_state;
    end
  end

  // break length counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brk_cnt <= 5'h00;
    end else if (state != ST_BREAK || next_state != ST_BREAK) begin
      brk_cnt <= 5'h00;
    end else begin
      brk_cnt <= brk_cnt + 5'h01;
    end
  end

  // link timer; a parameter so simulation can shorten it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmr <= '0;
    end else if (state != ST_LINKW) begin
      tmr <= '0;
    end else if (!tmr_hit) begin
      tmr <= tmr + 1'b1;
    end
  end

  // one-cycle completion event into the result capture
  // a pulse, so a cleared flag stays clear until the next completion
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done <= 1'b0;
    end else begin
      done <= (state == ST_LINKW) && (next_state == ST_UP);
    end
  end

  // ability word for the selected framing
  always_comb begin
    ability_tx = 16'h0001 << san_pkg::CW_SEL_BIT;
    if (!is_sgmii) begin
      ability_tx = adv_word;
    end else if (role_phy) begin
      ability_tx = adv_word;
      ability_tx[san_pkg::CW_SEL_BIT] = 1'b1;
      // advertised link bit is purely what software wrote
      ability_tx[san_pkg::CW_LINK_BIT] = adv_link;
    end
  end

  // break sends zeros; ability omits and later states add the acknowledge bit
  always_comb begin
    next_tx = 16'h0000;
    case (state)
      ST_BREAK: begin
        next_tx = 16'h0000;
      end
      default: begin
        next_tx = ability_tx;
        next_tx[san_pkg::CW_ACK_BIT] = (state != ST_ABILITY);
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_cfg_word_o <= 16'h0000;
      tx_cfg_en_o   <= 1'b1;
    end else begin
      tx_cfg_word_o <= next_tx;
      tx_cfg_en_o   <= (next_state != ST_UP);
    end
  end

  // attempt and success counters for field debugging
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      try_cnt <= 8'h00;
    end else if (state != ST_BREAK && next_state == ST_BREAK) begin
      try_cnt <= try_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_cnt <= 8'h00;
    end else if (done) begin
      up_cnt <= up_cnt + 8'h01;
    end
  end

  // read table: an entry hits only with the strobe, so with no read or an
  // unmapped address every entry is zero and so is the read data
  assign rd_val[0] = an.ctl_pend;
  assign rd_val[1] = an.sts;
  assign rd_val[2] = adv_word;
  assign rd_val[3] = an.pba;
  assign rd_val[4] = {up_cnt[4:0], try_cnt[4:0], role_phy, mode,
                      3'(state)};

  for (genvar g = 0; g < RD_N; g++) begin : g_rd
    assign rd_hit[g] = rd_i && (addr_i == RD_OFS[g]);
    assign rd_sel[g] = rd_hit[g] ? rd_val[g] : 16'h0000;
  end

  always_comb begin
    next_rd_data = 16'h0000;
    for (int k = 0; k < RD_N; k++) begin
      next_rd_data = next_rd_data | rd_sel[k];
    end
  end

  // read data stand for one cycle only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

  // result pins mirror the status flops
  assign an_done_o = an.sts[san_pkg::STS_DONE_BIT];
  assign link_up_o = an.sts[san_pkg::STS_LINK_BIT];
  assign speed_o   = an.sts[san_pkg::STS_SPD_LSB +: 2];
  assign duplex_o  = an.sts[san_pkg::STS_DPX_BIT];

  // kept combinational so the pin never lags a software clear
  // level interrupt, drops as soon as flag or enable clears
  assign irq_o = an.sts[san_pkg::STS_DONE_BIT] &
                 an.ctl_act[san_pkg::CTL_INTEN_BIT];
endmodule

// >>> san_ctl_shadow.sv
// pending and applied copies of the negotiation control register
`timescale 1ns/100ps
module san_ctl_shadow (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // register side
  san_an_if.shadow  an
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      an.ctl_pend <= san_pkg::CTL_RST;
    end else if (an.ctl_wr) begin
      an.ctl_pend <= an.wdata & san_pkg::CTL_WMASK;
    end
  end

  // the core negotiates only on the applied copy; register reads return the pending one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      an.ctl_act <= san_pkg::CTL_RST;
    end else if (an.adv_wr) begin
      an.ctl_act <= an.ctl_pend;
    end
  end

  // apply pulse lines up with the new applied copy
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      an.apply <= 1'b0;
    end else begin
      an.apply <= an.adv_wr;
    end
  end
endmodule

// >>> san_link_partner.sv
// behavioural far-end link partner answering the configuration exchange
`timescale 1ns/100ps
module san_link_partner (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // set by the bench
  input  wire logic [15:0] ability_i,
  input  wire logic        slow_i,
  // link towards the block
  input  wire logic [15:0] tx_cfg_word_i,
  input  wire logic        tx_cfg_en_i,
  output logic             rx_sync_o,
  output logic             rx_cfg_valid_o,
  output logic      [15:0] rx_cfg_word_o
);
  logic tick;
  logic send;

  // slow mode offers a word only every other cycle
  assign send = tx_cfg_en_i && (!slow_i || tick);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick <= 1'b0;
      rx_sync_o <= 1'b0;
      rx_cfg_valid_o <= 1'b0;
      rx_cfg_word_o <= 16'h0000;
    end else begin
      tick <= ~tick;
      rx_sync_o <= 1'b1;
      rx_cfg_valid_o <= send;
      // acknowledge once the block shows a nonzero ability word
      if (send) begin
        rx_cfg_word_o <= ability_i |
                         {1'b0, tx_cfg_word_i != 16'h0000, 14'h0000};
      end else begin
        // idle word toggles so a stale value is never mistaken for data
        rx_cfg_word_o <= ~rx_cfg_word_o;
      end
    end
  end
endmodule

// >>> san_pkg.sv
// shared constants for the serial gigabit auto-negotiation control block
package san_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // register addresses
  localparam logic [20:0] CTL_OFS = 21'h1f8001;
  localparam logic [20:0] STS_OFS = 21'h1f8002;
  localparam logic [20:0] ADV_OFS = 21'h1f0004;
  localparam logic [20:0] PBA_OFS = 21'h1f0005;
  localparam logic [20:0] DBG_OFS = 21'h1f8003;

  // control field positions
  localparam int CTL_INTEN_BIT = 0;
  localparam int CTL_MODE_LSB  = 1;
  localparam int CTL_ROLE_BIT  = 3;
  localparam int CTL_LINK_BIT  = 4;
  localparam logic [15:0] CTL_WMASK = 16'h001f;
  localparam logic [15:0] CTL_RST   = 16'h0004;

  // status field positions
  localparam int STS_DONE_BIT = 0;
  localparam int STS_DPX_BIT  = 1;
  localparam int STS_SPD_LSB  = 2;
  localparam int STS_LINK_BIT = 4;
  localparam logic [15:0] STS_RST = 16'h0000;
  localparam logic [15:0] ADV_RST = 16'h0000;
  localparam logic [15:0] PBA_RST = 16'h0000;

  // pcs mode codes
  localparam logic [1:0] MODE_SERDES = 2'b00;
  localparam logic [1:0] MODE_SGMII  = 2'b10;

  // link configuration word fields
  localparam int CW_SEL_BIT  = 0;
  localparam int CW_SPD_LSB  = 10;
  localparam int CW_DPX_BIT  = 12;
  localparam int CW_ACK_BIT  = 14;
  localparam int CW_LINK_BIT = 15;

  // negotiation timing
  localparam logic [1:0] MATCH_CNT = 2'h3;
  localparam int BREAK_CYC = 16;
  localparam int CLK_NS = 8;
  localparam int LINK_TMR_NS = 1600000;
  localparam int LINK_TMR_CYC = (LINK_TMR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 18;
endpackage

// >>> san_result_capture.sv
// negotiation results, sticky completion flag and partner ability word
`timescale 1ns/100ps
module san_result_capture (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // core side
  san_an_if.capture an
);
  logic       link;
  logic [1:0] speed;
  logic       duplex;
  logic       flag;

  // results decoded only from an sgmii partner
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link   <= 1'b0;
      speed  <= 2'b00;
      duplex <= 1'b0;
    end else if (an.done && an.sgmii) begin
      link   <= an.rx_word[san_pkg::CW_LINK_BIT];
      speed  <= an.rx_word[san_pkg::CW_SPD_LSB +: 2];
      duplex <= an.rx_word[san_pkg::CW_DPX_BIT];
    end
  end

  // 1000base-x results go to the ability word instead
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      an.pba <= san_pkg::PBA_RST;
    end else if (an.done && !an.sgmii) begin
      an.pba <= an.rx_word;
    end
  end

  // set wins over a same-cycle clear; enable plays no part
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag <= 1'b0;
    end else if (an.done) begin
      flag <= 1'b1;
    end else if (an.sts_wr && !an.wdata[san_pkg::STS_DONE_BIT]) begin
      flag <= 1'b0;
    end
  end

  assign an.sts = {11'h000, link, speed, duplex, flag};
endmodule

// >>> testbench.sv
// self-checking bench for the auto-negotiation control block
`timescale 1ns/100ps
module testbench;
  logic        clk_i, rst_b_i, wr_i, rd_i, rx_sync_i, rx_cfg_valid_i;
  logic        tx_cfg_en_o, an_done_o, link_up_o, duplex_o, irq_o;
  logic [20:0] addr_i;
  logic [15:0] wr_data_i, rd_data_o, rx_cfg_word_i, tx_cfg_word_o;
  logic [1:0]  speed_o, spd;
  logic [15:0] ability, w, txw, last_sts, pins;
  logic        slow, en, role, flag;
  logic [31:0] r;
  int          seed, bad_count, n_compared;

  // short link timer keeps each negotiation near fifty cycles
  san_autoneg_top #(.LINK_TMR_CYC(20)) i_san_autoneg_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .rx_sync_i(rx_sync_i), .rx_cfg_valid_i(rx_cfg_valid_i),
    .rx_cfg_word_i(rx_cfg_word_i), .tx_cfg_word_o(tx_cfg_word_o),
    .tx_cfg_en_o(tx_cfg_en_o), .an_done_o(an_done_o),
    .link_up_o(link_up_o), .speed_o(speed_o), .duplex_o(duplex_o),
    .irq_o(irq_o));
  san_link_partner i_san_link_partner (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ability_i(ability), .slow_i(slow),
    .tx_cfg_word_i(tx_cfg_word_o), .tx_cfg_en_i(tx_cfg_en_o),
    .rx_sync_o(rx_sync_i), .rx_cfg_valid_o(rx_cfg_valid_i),
    .rx_cfg_word_o(rx_cfg_word_i));

  // result pins packed in status layout for comparison
  assign pins = {11'h000, link_up_o, speed_o, duplex_o, an_done_o};

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [15:0] sts_exp(input logic [15:0] x);
    return {11'h000, x[15], x[11:10], x[12], 1'b1};
  endfunction

  task automatic chk(input string n, input logic [15:0] e, s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rchk(input logic [20:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rd_data", e, rd_data_o);
  endtask

  task automatic pause;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // waits for the exchange to finish, noting the ability word sent
  task automatic neg;
    int k;
    k = 0;
    txw = 16'h0000;
    repeat (4) @(posedge clk_i);
    #1;
    while (tx_cfg_en_o !== 1'b0 && k < 400) begin
      if (tx_cfg_word_o[14] === 1'b0 && tx_cfg_word_o !== 16'h0000) begin
        txw = tx_cfg_word_o;
      end
      @(posedge clk_i);
      #1;
      k++;
    end
    chk("negotiation_done", 16'h0000, 16'(tx_cfg_en_o));
    pause;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_of_test;
  end

  initial begin
    seed = 6;
    bad_count = 0;
    n_compared = 0;
    rst_b_i = 1'b0;
    addr_i = 21'h000000;
    wr_data_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ability = 16'h0001;
    slow = 1'b0;
    flag = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rchk(san_pkg::CTL_OFS, san_pkg::CTL_RST);
    rchk(san_pkg::STS_OFS, san_pkg::STS_RST);
    rchk(21'h1f8004, 16'h0000);
    wr(san_pkg::CTL_OFS, 16'hffe3);
    rchk(san_pkg::CTL_OFS, 16'h0003);
    for (int i = 0; i < 6; i++) begin
      spd = 2'({$random(seed)} % 3);
      r = $random(seed);
      w = {r[0], 2'b00, r[1], spd, 9'h000, 1'b1};
      ability = w;
      slow = i[1];
      en = i[0];
      role = (i == 5);
      wr(san_pkg::CTL_OFS, {11'h000, role, role, 2'b10, en});
      pause;
      chk("irq_pending", 16'(flag & ~en), 16'(irq_o));
      wr(san_pkg::ADV_OFS, 16'h0020);
      pause;
      chk("irq_applied", 16'(flag & en), 16'(irq_o));
      neg;
      chk("tx_ability", role ? 16'h8021 : 16'h0001, txw);
      rchk(san_pkg::STS_OFS, sts_exp(w));
      chk("result_pins", sts_exp(w), pins);
      chk("irq_done", 16'(en), 16'(irq_o));
      flag = 1'b1;
      if (i > 2) begin
        wr(san_pkg::STS_OFS, 16'hffff);
        pause;
        chk("flag_kept", 16'h0001, 16'(an_done_o));
        wr(san_pkg::STS_OFS, 16'h0000);
        pause;
        chk("flag_cleared", 16'h0000, 16'({an_done_o, irq_o}));
        flag = 1'b0;
      end
    end
    last_sts = sts_exp(w);
    // serdes and both reserved codes keep results out of the status fields
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        w = (16'($random(seed)) & 16'hbfff) | 16'h0020;
        ability = w;
        wr(san_pkg::CTL_OFS, {11'h000, 2'b11, 2'(m), 1'b0});
        wr(san_pkg::ADV_OFS, 16'h0020);
        neg;
        chk("tx_ability", 16'h0020, txw);
        rchk(san_pkg::PBA_OFS, w | 16'h4000);
        rchk(san_pkg::STS_OFS, last_sts);
        chk("result_pins", last_sts, pins);
      end
    end
    end_of_test;
  end
endmodule
